//--- logic/burst_sram_cfg.svh
// Constants for the burst SRAM port interface
`ifndef BURST_SRAM_CFG_SVH
`define BURST_SRAM_CFG_SVH

// Burst length and word index width
`define BURST_WORDS        4
`define WORD_IDX_W         2
`define FIRST_WORD         2'h0
`define LAST_WORD          2'h3
// Default organisation: 18-bit words, two byte masks
`define DEF_DATA_W         18
`define DEF_MASK_W         2
`define DEF_ADDR_W         6
`define WR_FIFO_DEPTH      8
// Write stages and strap settle count
`define WR_STAGES          5
`define STRAP_SETTLE       2'h3
`define STRAP_STEP         2'h1
// Pin synchroniser reset values
`define CLK_PINS_IDLE      4'h0
`define SEL_PINS_IDLE      2'h3

`endif

//--- logic/burst_sram_pkg.sv
// Types shared by the burst SRAM port interface
package burst_sram_pkg;

  typedef enum {
    RD_IDLE,
    RD_ARM,
    RD_BURST,
    RD_TAIL
  } rd_state_t;

endpackage

//--- logic/burst_sram_port_interface.sv
// Device side of a four-word burst SRAM with separate read and write ports
`timescale 1ns/100ps
`include "burst_sram_cfg.svh"

// Operation
// R1: A low write select at a main rise takes words at the pos and neg rises of t+1 and t+2.
// R2: A low read select at a main rise sends words from output neg t+1 to output pos t+3.
// R3: After reset the device is idle with read outputs off, and both selects high start nothing.
// R4: Stopped clocks hold all state.
// R5: A burst covers the latched location and the next three.
// R6: Writes are taken on input rises, reads leave on output rises or input rises in single clock mode.
// R7: A select that started an operation at the last main rise is ignored at this one.
// R8: A second read, or second write, on consecutive main rises is ignored.
// R9: Two nibble masks gate bits 3:0 and 7:4 in the 8-bit organisation.
// R10: Two byte masks gate bits 8:0 and 17:9 in the 18-bit organisation.
// R11: A word whose masks are all high changes no memory bit.
// R12: In the 9-bit organisation one mask gates the whole word.
// R13: Each word of a burst uses only its own masks.
// R14: Both output clocks high from power-on strap single clock mode.
module burst_sram_port_interface #(
  parameter int DATA_W     = `DEF_DATA_W,
  parameter int MASK_W     = `DEF_MASK_W,
  parameter int ADDR_W     = `DEF_ADDR_W,
  parameter int FIFO_DEPTH = `WR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  // Input clock pair
  input  wire logic              main_timing_pos_in,
  input  wire logic              main_timing_neg_in,
  // Output clock pair
  input  wire logic              output_timing_pos_in,
  input  wire logic              output_timing_neg_in,
  // Selects and address
  input  wire logic              read_port_select_n_in,
  input  wire logic              write_port_select_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  // Write port
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic [MASK_W-1:0] byte_write_mask_n_in,
  // Read port
  output logic [DATA_W-1:0]      rd_data_out,
  output logic                   rd_data_oe_out,
  output logic                   single_clock_mode_out
);
  import burst_sram_pkg::*;

  localparam int PIN_W  = 6 + ADDR_W + DATA_W + MASK_W;
  localparam int MEM_AW = ADDR_W + `WORD_IDX_W;
  localparam int FIFO_W = MEM_AW + DATA_W + MASK_W;
  localparam int CNT_W  = $clog2(FIFO_DEPTH + 1);
  localparam logic [PIN_W-1:0] PIN_RST = {`CLK_PINS_IDLE, `SEL_PINS_IDLE, {(PIN_W - 6){1'b0}}};

  //--------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------
  logic [PIN_W-1:0]  pin_raw, meta_q, meta_d, pin_q, pin_d;
  logic [3:0]        clk_prev_q, clk_prev_d;
  logic              m_pos, m_neg, o_pos, o_neg, rps_n_s, wps_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [MASK_W-1:0] mask_s;

  // One shared two-stage chain keeps clock-to-data skew
  assign pin_raw = {main_timing_pos_in, main_timing_neg_in, output_timing_pos_in, output_timing_neg_in,
                    read_port_select_n_in, write_port_select_n_in, addr_in, wr_data_in, byte_write_mask_n_in};
  assign {m_pos, m_neg, o_pos, o_neg, rps_n_s, wps_n_s, addr_s, data_s, mask_s} = pin_q;

  always_comb begin
    meta_d     = pin_raw;
    pin_d      = meta_q;
    clk_prev_d = pin_q[PIN_W-1 -: 4];
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta_q     <= PIN_RST;
      pin_q      <= PIN_RST;
      clk_prev_q <= `CLK_PINS_IDLE;
    end else begin
      meta_q     <= meta_d;
      pin_q      <= pin_d;
      clk_prev_q <= clk_prev_d;
    end
  end

  //--------------------------------------------------------------
  // Clock edges and single clock strap
  //--------------------------------------------------------------
  logic [3:0] clk_rise;
  logic       main_pos_ev, main_neg_ev, main_ev, out_pos_ev, out_neg_ev;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic       single_q, single_d, strap_done;

  assign clk_rise    = pin_q[PIN_W-1 -: 4] & ~clk_prev_q;
  assign main_pos_ev = clk_rise[3];
  assign main_neg_ev = clk_rise[2];
  // Stopped clocks give no edges, so all state holds
  assign main_ev     = main_pos_ev | main_neg_ev; // R4
  assign strap_done  = (strap_cnt_q == `STRAP_SETTLE);
  // Single clock mode: input pair times the outputs
  assign out_pos_ev  = single_q ? main_pos_ev : clk_rise[1]; // R6
  assign out_neg_ev  = single_q ? main_neg_ev : clk_rise[0]; // R6
  assign single_clock_mode_out = single_q;

  // Strap tracks the pins until settled, then freezes
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    single_d    = single_q;
    if (!strap_done) begin
      strap_cnt_d = strap_cnt_q + `STRAP_STEP;
      single_d    = o_pos & o_neg; // R14
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      strap_cnt_q <= '0;
      single_q    <= 1'b0;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      single_q    <= single_d;
    end
  end

  //--------------------------------------------------------------
  // Write capture
  //--------------------------------------------------------------
  logic [`WR_STAGES-1:0]  wr_stage_q, wr_stage_d;
  logic [ADDR_W-1:0]      wr_pend_q, wr_pend_d, wr_base_q, wr_base_d;
  logic [`WORD_IDX_W-1:0] wr_idx;
  logic                   wr_active, wr_room, wr_start, wr_capture;
  logic                   push_valid, push_ready;
  logic [FIFO_W-1:0]      push_data;
  logic [CNT_W-1:0]       fifo_level;

  // Stage k+1 set means the current main edge carries word k
  function automatic logic [`WORD_IDX_W-1:0] stage_idx(input logic [`WR_STAGES-1:0] s);
    stage_idx = s[4] ? `LAST_WORD : s[3] ? `WORD_IDX_W'(2) : s[2] ? `WORD_IDX_W'(1) : `FIRST_WORD;
  endfunction

  always_comb begin
    wr_active  = |wr_stage_q[`WR_STAGES-1:1];
    wr_idx     = stage_idx(wr_stage_q);
    // Refuse a start unless the FIFO fits the words due plus a burst
    wr_room    = (int'(fifo_level) + (wr_active ? `BURST_WORDS - int'(wr_idx) : 0) + `BURST_WORDS) <= FIFO_DEPTH;
    wr_start   = main_pos_ev & ~wps_n_s & ~wr_stage_q[1] & wr_room & strap_done; // R1 R3 R7 R8
    wr_capture = main_ev & wr_active; // R1 R6
    wr_stage_d = main_ev ? {wr_stage_q[`WR_STAGES-2:0], wr_start} : wr_stage_q;
    wr_pend_d  = wr_start ? addr_s : wr_pend_q;
    wr_base_d  = (wr_capture && wr_idx == `FIRST_WORD) ? wr_pend_q : wr_base_q;
    // Word k lands at the burst location's k-th slot
    push_data  = {(wr_idx == `FIRST_WORD) ? wr_pend_q : wr_base_q, wr_idx, data_s, mask_s}; // R5 R13
    // All masks high: word dropped
    push_valid = wr_capture & ~(&mask_s) & push_ready; // R11
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wr_stage_q <= '0;
      wr_pend_q  <= '0;
      wr_base_q  <= '0;
    end else begin
      wr_stage_q <= wr_stage_d;
      wr_pend_q  <= wr_pend_d;
      wr_base_q  <= wr_base_d;
    end
  end

  //--------------------------------------------------------------
  // Write FIFO and word array
  //--------------------------------------------------------------
  logic              fifo_out_valid, fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic              rd_en;
  logic [MEM_AW-1:0] rd_addr;

  mem_wr_if #(.DATA_W(DATA_W), .MASK_W(MASK_W), .AW(MEM_AW)) wr_bus ();

  assign wr_bus.valid   = fifo_out_valid;
  assign wr_bus.addr    = fifo_out_data[FIFO_W-1 -: MEM_AW];
  assign wr_bus.data    = fifo_out_data[DATA_W+MASK_W-1 -: DATA_W];
  assign wr_bus.mask_n  = fifo_out_data[MASK_W-1:0];
  assign fifo_out_ready = wr_bus.ready;

  burst_word_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_wr_fifo (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data),
    .level_out     (fifo_level)
  );

  sram_word_array #(.DATA_W(DATA_W), .MASK_W(MASK_W), .AW(MEM_AW)) u_array (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .wr          (wr_bus),
    .rd_en_in    (rd_en),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_data_out)
  );

  //--------------------------------------------------------------
  // Read sequencer
  //--------------------------------------------------------------
  rd_state_t              rd_state_q, rd_state_d;
  logic [`WORD_IDX_W-1:0] rd_idx_q, rd_idx_d;
  logic [ADDR_W-1:0]      rd_cur_q, rd_cur_d, rd_next_q, rd_next_d;
  logic                   rd_next_v_q, rd_next_v_d, rd_prev_q, rd_prev_d;
  logic                   rd_oe_q, rd_oe_d, rd_start, rd_edge;

  assign rd_data_oe_out = rd_oe_q;

  always_comb begin
    rd_state_d  = rd_state_q;
    rd_idx_d    = rd_idx_q;
    rd_cur_d    = rd_cur_q;
    rd_next_d   = rd_next_q;
    rd_next_v_d = rd_next_v_q;
    rd_oe_d     = rd_oe_q;
    rd_en       = 1'b0;
    rd_addr     = {rd_cur_q, rd_idx_q};
    rd_start    = main_pos_ev & ~rps_n_s & ~rd_prev_q & strap_done; // R2 R3 R7 R8
    rd_prev_d   = main_pos_ev ? rd_start : rd_prev_q;
    // Even words on output neg rises, odd on pos
    rd_edge     = rd_idx_q[0] ? out_pos_ev : out_neg_ev; // R2 R6
    case (rd_state_q)
      RD_IDLE: begin
        if (rd_next_v_q) begin
          rd_state_d = RD_ARM;
        end
      end
      RD_ARM: begin
        // Output pos rise of t+1 precedes the first word
        if (out_pos_ev) begin
          rd_state_d = RD_BURST;
          rd_idx_d   = `FIRST_WORD;
        end
      end
      RD_BURST: begin
        if (rd_edge) begin
          rd_en    = 1'b1;
          rd_oe_d  = 1'b1;
          rd_idx_d = rd_idx_q + `WORD_IDX_W'(1); // R5
          if (rd_idx_q == `FIRST_WORD) begin
            rd_addr     = {rd_next_q, `FIRST_WORD};
            rd_cur_d    = rd_next_q;
            rd_next_v_d = 1'b0;
          end
          // A read two rises later follows seamlessly
          if (rd_idx_q == `LAST_WORD) begin
            rd_state_d = rd_next_v_q ? RD_BURST : RD_TAIL;
          end
        end
      end
      RD_TAIL: begin
        // Float half a cycle after the last word
        if (out_neg_ev) begin
          rd_oe_d    = 1'b0; // R3
          rd_state_d = rd_next_v_q ? RD_ARM : RD_IDLE;
        end
      end
      default: begin
        rd_state_d = RD_IDLE;
      end
    endcase
    if (rd_start) begin
      rd_next_d   = addr_s;
      rd_next_v_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rd_state_q  <= RD_IDLE;
      rd_idx_q    <= `FIRST_WORD;
      rd_cur_q    <= '0;
      rd_next_q   <= '0;
      rd_next_v_q <= 1'b0;
      rd_prev_q   <= 1'b0;
      rd_oe_q     <= 1'b0; // R3
    end else begin
      rd_state_q  <= rd_state_d;
      rd_idx_q    <= rd_idx_d;
      rd_cur_q    <= rd_cur_d;
      rd_next_q   <= rd_next_d;
      rd_next_v_q <= rd_next_v_d;
      rd_prev_q   <= rd_prev_d;
      rd_oe_q     <= rd_oe_d;
    end
  end
endmodule

//--- logic/burst_word_fifo.sv
// Parameterised FIFO holding captured write words
`timescale 1ns/100ps
module burst_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out,
  // Fill level
  output logic [CNT_W-1:0]      level_out
);
  import burst_sram_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             push, pop;

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    ptr_next = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  assign in_ready_out  = (cnt_q != CNT_W'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = buf_q[rd_ptr_q];
  assign level_out     = cnt_q;

  always_comb begin
    push     = in_valid_in & in_ready_out;
    pop      = out_valid_out & out_ready_in;
    wr_ptr_d = push ? ptr_next(wr_ptr_q) : wr_ptr_q;
    rd_ptr_d = pop ? ptr_next(rd_ptr_q) : rd_ptr_q;
    cnt_d    = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CNT_W'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
    end
  end

  // Storage is not reset; only the pointers and count guard its contents
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      buf_q[wr_ptr_q] <= in_data_in;
    end
  end
endmodule

//--- logic/mem_wr_if.sv
// Write request carrier between the write FIFO and the word array
`timescale 1ns/100ps
interface mem_wr_if #(
  parameter int DATA_W = 18,
  parameter int MASK_W = 2,
  parameter int AW     = 8
) ();
  logic              valid;
  logic              ready;
  logic [AW-1:0]     addr;
  logic [DATA_W-1:0] data;
  logic [MASK_W-1:0] mask_n;

  modport source (output valid, output addr, output data, output mask_n, input ready);
  modport sink   (input valid, input addr, input data, input mask_n, output ready);
endinterface

//--- logic/sram_word_array.sv
// Single-port word array with lane masks; reads take priority over writes
`timescale 1ns/100ps
module sram_word_array #(
  parameter int DATA_W = 18,
  parameter int MASK_W = 2,
  parameter int AW     = 8
) (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  // Masked write requests
  mem_wr_if.sink                 wr,
  // Read port, data one cycle after the request
  input  wire logic              rd_en_in,
  input  wire logic [AW-1:0]     rd_addr_in,
  output logic [DATA_W-1:0]      rd_data_out
);
  import burst_sram_pkg::*;

  localparam int LANE_W = DATA_W / MASK_W;

  logic [DATA_W-1:0] mem_q [2**AW];
  logic [DATA_W-1:0] rd_data_q, rd_data_d;
  logic [DATA_W-1:0] merged;
  logic              wr_en;

  // Each active-low mask bit owns one lane
  function automatic logic [DATA_W-1:0] lane_enables(input logic [MASK_W-1:0] m_n);
    for (int i = 0; i < DATA_W; i++) begin
      lane_enables[i] = ~m_n[i / LANE_W];
    end
  endfunction

  // Reads win the single port; the FIFO drain stalls
  assign wr.ready    = ~rd_en_in;
  assign rd_data_out = rd_data_q;

  always_comb begin
    wr_en     = wr.valid & wr.ready;
    // Masked lanes keep their stored bits
    merged    = (wr.data & lane_enables(wr.mask_n)) | (mem_q[wr.addr] & ~lane_enables(wr.mask_n)); // R9 R10 R12
    rd_data_d = rd_en_in ? mem_q[rd_addr_in] : rd_data_q;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (wr_en) begin
      mem_q[wr.addr] <= merged;
    end
  end
endmodule

//--- tb/burst_sram_port_interface_checker.sv
// Concurrent checks on the pins of the burst SRAM port interface
`timescale 1ns/100ps
module burst_sram_port_interface_checker #(
  parameter int DATA_W = 18,
  parameter int MASK_W = 2,
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic              core_clk_in,
  input wire logic              rst_n_in,
  // Pins
  input wire logic              main_timing_pos_in,
  input wire logic              main_timing_neg_in,
  input wire logic              output_timing_pos_in,
  input wire logic              output_timing_neg_in,
  input wire logic              read_port_select_n_in,
  input wire logic              write_port_select_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic [MASK_W-1:0] byte_write_mask_n_in,
  // Outputs
  input wire logic [DATA_W-1:0] rd_data_out,
  input wire logic              rd_data_oe_out,
  input wire logic              single_clock_mode_out
);
  // ----------------------------------------
  // Edge history
  // ----------------------------------------
  // Outputs trail a pin edge by 3 to 5 cycles
  logic       mpos_q, mneg_q, opos_q, oneg_q, mpos_rise, neg_rise, any_rise, rd_prev_q, rd_prev_d;
  logic [4:0] neg_h_q, any_h_q;
  logic [2:0] rd_ago_q, rd_ago_d;
  logic [3:0] rel_q, rel_d;
  always_comb begin
    mpos_rise = main_timing_pos_in & ~mpos_q;
    neg_rise  = single_clock_mode_out ? main_timing_neg_in & ~mneg_q : output_timing_neg_in & ~oneg_q;
    any_rise  = neg_rise | (single_clock_mode_out ? mpos_rise : output_timing_pos_in & ~opos_q);
    rd_prev_d = rd_prev_q;
    rd_ago_d  = rd_ago_q;
    rel_d     = (rel_q == 4'hf) ? rel_q : rel_q + 4'h1;
    if (mpos_rise) begin
      rd_prev_d = !read_port_select_n_in && !rd_prev_q;
      rd_ago_d  = rd_prev_d ? 3'h0 : (rd_ago_q == 3'h7) ? rd_ago_q : rd_ago_q + 3'h1;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      {mpos_q, mneg_q, opos_q, oneg_q, rd_prev_q} <= 5'h00;
      {neg_h_q, any_h_q} <= 10'h000;
      rd_ago_q <= 3'h7;
      rel_q <= 4'h0;
    end else begin
      {mpos_q, mneg_q, opos_q, oneg_q} <= {main_timing_pos_in, main_timing_neg_in, output_timing_pos_in,
                                           output_timing_neg_in};
      rd_prev_q <= rd_prev_d;
      rd_ago_q <= rd_ago_d;
      rel_q <= rel_d;
      neg_h_q <= {neg_h_q[3:0], neg_rise};
      any_h_q <= {any_h_q[3:0], any_rise};
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |=> !rd_data_oe_out && rd_data_out == '0
    && !single_clock_mode_out) else $error("outputs active after reset");
  a_idle_no_drive: assert property (rd_ago_q == 3'h7 |-> !rd_data_oe_out)
    else $error("read bus driven while idle");
  a_oe_after_start: assert property ($rose(rd_data_oe_out) |-> rd_ago_q inside {[3'h1:3'h2]})
    else $error("read bus driven at wrong cycle");
  a_oe_rise_edge: assert property ($rose(rd_data_oe_out) |-> |neg_h_q[4:2])
    else $error("enable off an output neg edge");
  a_oe_fall_edge: assert property ($fell(rd_data_oe_out) |-> |neg_h_q[4:2])
    else $error("release off an output neg edge");
  a_data_on_edge: assert property (rd_data_oe_out && $past(rd_data_oe_out) && $changed(rd_data_out)
    |-> |any_h_q[4:2]) else $error("word changed off an output edge");
  a_burst_min_len: assert property ($rose(rd_data_oe_out) |=> rd_data_oe_out [*7])
    else $error("burst too short");
  a_strap_fixed: assert property (rel_q == 4'hf |-> $stable(single_clock_mode_out))
    else $error("clock mode changed");
  c_read: cover property ($rose(rd_data_oe_out));
  c_single_read: cover property (single_clock_mode_out && $rose(rd_data_oe_out));
  c_doubled_read: cover property (mpos_rise && !read_port_select_n_in && rd_prev_q);
endmodule

bind burst_sram_port_interface burst_sram_port_interface_checker #(
  .DATA_W(DATA_W), .MASK_W(MASK_W), .ADDR_W(ADDR_W)) burst_sram_port_interface_checker_i (
  .core_clk_in, .rst_n_in, .main_timing_pos_in, .main_timing_neg_in, .output_timing_pos_in,
  .output_timing_neg_in, .read_port_select_n_in, .write_port_select_n_in, .addr_in, .wr_data_in,
  .byte_write_mask_n_in, .rd_data_out, .rd_data_oe_out, .single_clock_mode_out);

//--- tb/burst_sram_port_interface_test.sv
// Self-checking bench for the burst SRAM port interface
`timescale 1ns/100ps
module burst_sram_port_interface_test;
  import burst_sram_pkg::*;
  localparam int DATA_W = 18, MASK_W = 2, ADDR_W = 6, LANE = DATA_W / MASK_W;
  logic              core_clk_in, rst_n_in, mpos, mneg, opos, oneg, rs_n, ws_n, oe, single;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd, rd;
  logic [MASK_W-1:0] mask;
  logic [DATA_W-1:0] exp_mem [2**(ADDR_W+2)];
  logic [DATA_W-1:0] exp_q[$];
  int                n_errors, comparisons;
  burst_sram_port_interface burst_sram_port_interface_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .main_timing_pos_in(mpos), .main_timing_neg_in(mneg), .output_timing_pos_in(opos),
    .output_timing_neg_in(oneg), .read_port_select_n_in(rs_n), .write_port_select_n_in(ws_n),
    .addr_in(addr), .wr_data_in(wd), .byte_write_mask_n_in(mask), .rd_data_out(rd),
    .rd_data_oe_out(oe), .single_clock_mode_out(single));
  sram_ctrl_model sram_ctrl_model_i (.core_clk_in(core_clk_in), .rd_data_in(rd), .rd_data_oe_in(oe),
    .main_pos_out(mpos), .main_neg_out(mneg), .out_pos_out(opos), .out_neg_out(oneg), .rd_sel_n_out(rs_n),
    .wr_sel_n_out(ws_n), .addr_out(addr), .wr_data_out(wd), .mask_n_out(mask));
  // ----------
  // Tasks
  // ----------
  task automatic check_word(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic check_count(input int e, input int g);
    comparisons++;
    if (g != e) begin
      n_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) sram_ctrl_model_i.cycle(1'b1, 1'b1, '0, '0, '1);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0][DATA_W-1:0] d, input logic [3:0][MASK_W-1:0] m);
    sram_ctrl_model_i.cycle(1'b1, 1'b0, a, d, m);
    for (int k = 0; k < 4; k++)
      for (int l = 0; l < MASK_W; l++)
        if (!m[k][l]) exp_mem[{a, k[1:0]}][l*LANE +: LANE] = d[k][l*LANE +: LANE];
  endtask
  task automatic rd_start(input logic [ADDR_W-1:0] a);
    sram_ctrl_model_i.cycle(1'b0, 1'b1, a, '0, '1);
    for (int k = 0; k < 4; k++) exp_q.push_back(exp_mem[{a, k[1:0]}]);
  endtask
  task automatic drain();
    idle(4);
    check_count(exp_q.size(), sram_ctrl_model_i.rd_q.size());
    while (exp_q.size() > 0 && sram_ctrl_model_i.rd_q.size() > 0)
      check_word(exp_q.pop_front(), sram_ctrl_model_i.rd_q.pop_front());
    exp_q.delete();
    sram_ctrl_model_i.rd_q.delete();
  endtask
  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset_idle();
    check_word(18'h00000, {17'h00000, oe});
    check_word(18'h00000, {17'h00000, single});
  endtask
  task automatic t_burst_order();
    wr(6'h05, {18'h3a004, 18'h2b003, 18'h1c002, 18'h0d001}, '0);
    rd_start(6'h05);
    drain();
  endtask
  task automatic t_lane_masks();
    wr(6'h09, {4{18'h00000}}, '0);
    idle(1);
    wr(6'h09, {4{18'h3ffff}}, {2'h3, 2'h2, 2'h1, 2'h0});
    idle(1);
    rd_start(6'h09);
    drain();
  endtask
  task automatic t_doubled();
    wr(6'h12, {18'h01234, 18'h05678, 18'h09abc, 18'h0def0}, '0);
    idle(1);
    wr(6'h11, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, '0);
    sram_ctrl_model_i.cycle(1'b1, 1'b0, 6'h12, {4{18'h3c3c3}}, '0);
    idle(1);
    rd_start(6'h11);
    sram_ctrl_model_i.cycle(1'b0, 1'b1, 6'h05, '0, '1);
    rd_start(6'h12);
    drain();
  endtask
  task automatic t_nop_stop();
    idle(3);
    sram_ctrl_model_i.park(20);
    idle(1);
    rd_start(6'h05);
    drain();
  endtask
  task automatic t_strap();
    sram_ctrl_model_i.set_single(1'b1);
    do_reset();
    check_word(18'h00001, {17'h00000, single});
    wr(6'h20, {18'h2468a, 18'h13579, 18'h0fedc, 18'h3ba98}, '0);
    idle(1);
    rd_start(6'h20);
    drain();
  endtask
  // ----------
  // Main sequence
  // ----------
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #(20000 * 25);
    n_errors++;
    print_verdict();
  end
  initial begin
    rst_n_in = 1'b0;
    n_errors = 0;
    comparisons = 0;
    do_reset();
    t_reset_idle();
    t_burst_order();
    t_lane_masks();
    t_doubled();
    t_nop_stop();
    t_strap();
    print_verdict();
  end
endmodule

//--- tb/sram_ctrl_model.sv
// Memory controller model driving the burst SRAM pins
`timescale 1ns/100ps
module sram_ctrl_model #(
  parameter int DATA_W = 18,
  parameter int MASK_W = 2,
  parameter int ADDR_W = 6
) (
  // Clock and read port
  input  wire logic              core_clk_in,
  input  wire logic [DATA_W-1:0] rd_data_in,
  input  wire logic              rd_data_oe_in,
  // Pins toward the device
  output logic                   main_pos_out,
  output logic                   main_neg_out,
  output logic                   out_pos_out,
  output logic                   out_neg_out,
  output logic                   rd_sel_n_out,
  output logic                   wr_sel_n_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      wr_data_out,
  output logic [MASK_W-1:0]      mask_n_out
);
  logic [DATA_W-1:0] wq[$];
  logic [MASK_W-1:0] mq[$];
  logic [DATA_W-1:0] rd_q[$];
  logic              single, wr_prev;
  initial begin
    {main_pos_out, main_neg_out, out_pos_out, out_neg_out} = 4'h0;
    {rd_sel_n_out, wr_sel_n_out, single, wr_prev} = 4'hc;
    addr_out = '0;
    wr_data_out = '0;
    mask_n_out = '1;
  end
  // One six-cycle phase; idle lines show the inverse of their last value
  task automatic half(input logic ph, input logic rs_n, input logic ws_n, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    logic [MASK_W-1:0] m;
    d = ~wr_data_out;
    m = ~mask_n_out;
    if (wq.size() > 0) begin
      d = wq.pop_front();
      m = mq.pop_front();
    end
    @(posedge core_clk_in);
    main_pos_out <= ph;
    main_neg_out <= !ph;
    out_pos_out <= single | ph;
    out_neg_out <= single | !ph;
    rd_sel_n_out <= rs_n;
    wr_sel_n_out <= ws_n;
    addr_out <= (rs_n && ws_n) ? ~addr_out : a;
    wr_data_out <= d;
    mask_n_out <= m;
    repeat (5) @(posedge core_clk_in);
    #1;
    if (rd_data_oe_in === 1'b1) rd_q.push_back(rd_data_in);
  endtask
  task automatic cycle(input logic rs_n, input logic ws_n, input logic [ADDR_W-1:0] a,
                       input logic [3:0][DATA_W-1:0] wd, input logic [3:0][MASK_W-1:0] wm);
    half(1'b1, rs_n, ws_n, a);
    half(1'b0, 1'b1, 1'b1, a);
    // Words follow from the next pos phase; a doubled write sends none
    wr_prev = !ws_n && !wr_prev;
    if (wr_prev) for (int k = 0; k < 4; k++) begin
      wq.push_back(wd[k]);
      mq.push_back(wm[k]);
    end
  endtask
  task automatic park(input int n);
    @(posedge core_clk_in);
    {main_pos_out, main_neg_out, out_pos_out, out_neg_out} <= 4'h3;
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic set_single(input logic b);
    single = b;
    park(1);
  endtask
endmodule
